// >>> include/sbc_supervisor_pkg.sv
// Purpose: shared constants and types of the supervision timing block
// Assumes: clk_sys at 250 MHz, every timer derived from it
// Notes:   times are kept in their own unit, tick counts derive from them

package sbc_supervisor_pkg;

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int US_NS         = 1000;
	localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;
	localparam int US_PER_MS     = 1000;

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	localparam int         WD_SEL_W     = 3;
	localparam logic [2:0] WD_SEL_RESET = 3'h0;
	localparam int         WD_BASE_MS   = 8;
	localparam int         WD_BASE_US   = WD_BASE_MS * US_PER_MS;
	localparam int         WD_CNT_W     = 20;

	// ----------------------------------------------------------------
	// fail-safe patterns
	// ----------------------------------------------------------------
	localparam int SLOW_FREQ_CHZ  = 125;
	localparam int SLOW_PERIOD_MS = 100 * US_PER_MS / SLOW_FREQ_CHZ;
	localparam int SLOW_DUTY_PCT  = 50;
	localparam int SLOW_LOW_MS    = SLOW_PERIOD_MS * SLOW_DUTY_PCT / 100;
	localparam int FAST_FREQ_HZ   = 100;
	localparam int FAST_PERIOD_MS = US_PER_MS / FAST_FREQ_HZ;
	localparam int FAST_DUTY_PCT  = 20;
	localparam int FAST_LOW_MS    = FAST_PERIOD_MS * FAST_DUTY_PCT / 100;
	localparam int MS_CNT_W       = 10;

	// ----------------------------------------------------------------
	// interrupt, reset line, wake, spi gap
	// ----------------------------------------------------------------
	localparam int INT_ACTIVE_MS  = 1;
	localparam int INT_ACTIVE_US  = INT_ACTIVE_MS * US_PER_MS;
	localparam int INT_SPACING_MS = 5;
	localparam int INT_SPACING_US = INT_SPACING_MS * US_PER_MS;
	localparam int RST_FILT_US    = 5;
	localparam int CLAMP_HIGH_MS  = 1;
	localparam int CLAMP_HIGH_US  = CLAMP_HIGH_MS * US_PER_MS;
	localparam int CLAMP_LOW_MS   = 250;
	localparam int WAKE_FILT_US   = 30;
	localparam int SPI_GAP_US     = 10;
	localparam int US_CNT_W       = 13;

	typedef struct packed {
		logic staticOeN;
		logic slowOeN;
		logic fastOeN;
	} failsafe_pins_t;

	typedef struct packed {
		logic clampedHigh;
		logic clampedLow;
		logic spiGapViolation;
	} line_status_t;

	typedef enum logic [1:0] {INT_IDLE, INT_ACTIVE, INT_HOLD} int_state_t;

endpackage

// >>> src/tick_divider.sv
// Purpose: one-cycle enable pulse every DIV enabled cycles
// Assumes: en is a one-cycle pulse or held high
// Notes:   the tick lags the wrapping enable by one cycle

module tick_divider #(
	parameter int DIV = 250
) (
	input  wire logic clk_sys, // system clock
	input  wire logic rst_n,   // synchronous reset, active low
	input  wire logic en,      // count enable
	output logic      tick     // one-cycle pulse per DIV enables
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

	logic [W-1:0] cnt_q;
	wire          wrap = en && (cnt_q == W'(DIV - 1));

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end
		else
		begin
			tick <= wrap;
			if (en)
				cnt_q <= wrap ? '0 : cnt_q + 1'b1;
		end
	end
endmodule

// >>> src/sbc_supervisor_timing.sv
// Purpose: watchdog, fail-safe patterns, interrupt shaping, reset line and wake filters
// Assumes: all inputs synchronous to clk_sys; open-drain pins given as enables, low = pull low
// Notes:   timers run on a 1 us and a 1 ms tick so no counter but the watchdog count exceeds a few thousand

// How it works
// - eight watchdog periods, 8 ms doubling to 1024
// - each period within ten percent of nominal
// - slow fail-safe toggles 1.25 Hz, 50 percent
// - fast fail-safe pattern 100 Hz, 20 percent
// - fail-safe released idle, pulled low when active
// - interrupt pulse low for 1 ms
// - at least 5 ms between interrupt requests
// - reset line lows shorter than filter ignored
// - flag reset line clamped high or low
// - wake accepted after level persists filter time
module sbc_supervisor_timing (
	input  wire logic                          clk_sys,              // system clock
	input  wire logic                          rst_n,                // synchronous reset, active low
	input  wire logic [2:0]                    wdPeriodSelect,       // period code written over spi
	input  wire logic                          wdPeriodWrite,        // write strobe for the period code
	input  wire logic                          wdTrigger,            // watchdog service pulse
	input  wire logic                          failsafeInternalFlag, // enables slow pattern
	input  wire logic                          failsafeStaticReq,    // static fail-safe active
	input  wire logic                          failsafeFastReq,      // enables fast pattern
	input  wire logic                          irqEvent,             // interrupt request pulse
	input  wire logic                          resetDriveReq,        // device wants reset line low
	input  wire logic                          resetLineN,           // sampled reset line level
	input  wire logic                          localWakeInput,       // wake pin level
	input  wire logic                          spiCsN,               // spi chip select, active low
	output logic                               wdTimeout,            // pulse on expiry
	output sbc_supervisor_pkg::failsafe_pins_t failsafePins,         // fail-safe pin enables
	output logic                               interruptOeN,         // interrupt pin enable
	output logic                               resetLineOeN,         // reset pin enable
	output logic                               resetDetected,        // pulse on filtered reset line low, also when the device drives it
	output sbc_supervisor_pkg::line_status_t   lineStatus,           // clamp and gap flags
	output logic                               wakeEvent,            // pulse on accepted wake change
	output logic                               wakeLevel             // filtered wake level
);

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	logic usTick;
	logic msTick;

	tick_divider #(.DIV(sbc_supervisor_pkg::CYCLES_PER_US)) usDiv (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.en      (1'b1),
		.tick    (usTick)
	);

	tick_divider #(.DIV(sbc_supervisor_pkg::US_PER_MS)) msDiv (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.en      (usTick),
		.tick    (msTick)
	);

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	function automatic logic [sbc_supervisor_pkg::WD_CNT_W-1:0] wdLimitOf(input logic [2:0] sel);
		wdLimitOf = sbc_supervisor_pkg::WD_CNT_W'(sbc_supervisor_pkg::WD_BASE_US) << sel;
	endfunction

	logic [2:0]                              wdSelPend_q;
	logic [2:0]                              wdSelAct_q;
	logic [sbc_supervisor_pkg::WD_CNT_W-1:0] wdCnt_q;

	// counting whole microseconds keeps the error below 1 us, far inside the tolerance
	wire [sbc_supervisor_pkg::WD_CNT_W-1:0] wdLimit  = wdLimitOf(wdSelAct_q);
	wire                                    wdExpire = usTick && (wdCnt_q == wdLimit - 1'b1);
	wire                                    wdStart  = wdTrigger || wdExpire;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wdSelPend_q <= sbc_supervisor_pkg::WD_SEL_RESET;
			wdSelAct_q  <= sbc_supervisor_pkg::WD_SEL_RESET;
			wdCnt_q     <= '0;
			wdTimeout   <= 1'b0;
		end
		else
		begin
			wdTimeout <= wdExpire;
			if (wdPeriodWrite)
				wdSelPend_q <= wdPeriodSelect;
			if (wdStart)
			begin
				wdSelAct_q <= wdPeriodWrite ? wdPeriodSelect : wdSelPend_q;
				wdCnt_q    <= '0;
			end
			else if (usTick)
				wdCnt_q <= wdCnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// fail-safe patterns
	// ----------------------------------------------------------------
	logic [sbc_supervisor_pkg::MS_CNT_W-1:0] slowCnt_q;
	logic [sbc_supervisor_pkg::MS_CNT_W-1:0] fastCnt_q;

	// patterns restart in the low phase each time they are enabled
	wire slowWrap  = slowCnt_q == sbc_supervisor_pkg::MS_CNT_W'(sbc_supervisor_pkg::SLOW_PERIOD_MS - 1);
	wire fastWrap  = fastCnt_q == sbc_supervisor_pkg::MS_CNT_W'(sbc_supervisor_pkg::FAST_PERIOD_MS - 1);
	wire slowLow   = failsafeInternalFlag && (slowCnt_q < sbc_supervisor_pkg::SLOW_LOW_MS);
	wire fastLow   = failsafeFastReq && (fastCnt_q < sbc_supervisor_pkg::FAST_LOW_MS);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			slowCnt_q    <= '0;
			fastCnt_q    <= '0;
			failsafePins <= '1;
		end
		else
		begin
			if (!failsafeInternalFlag)
				slowCnt_q <= '0;
			else if (msTick)
				slowCnt_q <= slowWrap ? '0 : slowCnt_q + 1'b1;
			if (!failsafeFastReq)
				fastCnt_q <= '0;
			else if (msTick)
				fastCnt_q <= fastWrap ? '0 : fastCnt_q + 1'b1;
			failsafePins.staticOeN <= !failsafeStaticReq;
			failsafePins.slowOeN   <= !slowLow;
			failsafePins.fastOeN   <= !fastLow;
		end
	end

	// ----------------------------------------------------------------
	// interrupt pulse shaping
	// ----------------------------------------------------------------
	sbc_supervisor_pkg::int_state_t          intState_q;
	logic                                    intPend_q;
	logic [sbc_supervisor_pkg::US_CNT_W-1:0] intCnt_q;

	wire intTake   = (intState_q == sbc_supervisor_pkg::INT_IDLE) && intPend_q;
	wire intActEnd = usTick && (intCnt_q == sbc_supervisor_pkg::US_CNT_W'(sbc_supervisor_pkg::INT_ACTIVE_US - 1));
	wire intGapEnd = usTick && (intCnt_q == sbc_supervisor_pkg::US_CNT_W'(sbc_supervisor_pkg::INT_SPACING_US - 1));

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			intState_q   <= sbc_supervisor_pkg::INT_IDLE;
			intPend_q    <= 1'b0;
			intCnt_q     <= '0;
			interruptOeN <= 1'b1;
		end
		else
		begin
			// a request arriving while the pending one is taken is kept
			intPend_q <= irqEvent || (intPend_q && !intTake);
			if (usTick)
				intCnt_q <= intCnt_q + 1'b1;
			case (intState_q)
				sbc_supervisor_pkg::INT_IDLE:
				begin
					if (intPend_q)
					begin
						intState_q   <= sbc_supervisor_pkg::INT_ACTIVE;
						intCnt_q     <= '0;
						interruptOeN <= 1'b0;
					end
				end
				sbc_supervisor_pkg::INT_ACTIVE:
				begin
					if (intActEnd)
					begin
						intState_q   <= sbc_supervisor_pkg::INT_HOLD;
						interruptOeN <= 1'b1;
					end
				end
				sbc_supervisor_pkg::INT_HOLD:
				begin
					if (intGapEnd)
						intState_q <= sbc_supervisor_pkg::INT_IDLE;
				end
				default:
				begin
					intState_q   <= sbc_supervisor_pkg::INT_IDLE;
					interruptOeN <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// reset line filter and clamp detection
	// ----------------------------------------------------------------
	logic [sbc_supervisor_pkg::US_CNT_W-1:0] rstLowUs_q;
	logic [sbc_supervisor_pkg::US_CNT_W-1:0] rstHighUs_q;
	logic [sbc_supervisor_pkg::MS_CNT_W-1:0] rstLowMs_q;

	wire rstFiltHit  = usTick && !resetLineN
		&& (rstLowUs_q == sbc_supervisor_pkg::US_CNT_W'(sbc_supervisor_pkg::RST_FILT_US - 1));
	wire clampHiHit  = usTick && resetDriveReq && resetLineN
		&& (rstHighUs_q == sbc_supervisor_pkg::US_CNT_W'(sbc_supervisor_pkg::CLAMP_HIGH_US - 1));
	wire clampLoHit  = msTick && !resetLineN && !resetDriveReq
		&& (rstLowMs_q == sbc_supervisor_pkg::MS_CNT_W'(sbc_supervisor_pkg::CLAMP_LOW_MS - 1));

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rstLowUs_q    <= '0;
			rstHighUs_q   <= '0;
			rstLowMs_q    <= '0;
			resetDetected <= 1'b0;
			resetLineOeN  <= 1'b1;
		end
		else
		begin
			resetLineOeN  <= !resetDriveReq;
			resetDetected <= rstFiltHit;
			// counters stop one past their threshold so each hit fires once
			if (resetLineN)
				rstLowUs_q <= '0;
			else if (usTick && rstLowUs_q < sbc_supervisor_pkg::RST_FILT_US)
				rstLowUs_q <= rstLowUs_q + 1'b1;
			if (!resetDriveReq || !resetLineN)
				rstHighUs_q <= '0;
			else if (usTick && rstHighUs_q < sbc_supervisor_pkg::CLAMP_HIGH_US)
				rstHighUs_q <= rstHighUs_q + 1'b1;
			if (resetLineN || resetDriveReq)
				rstLowMs_q <= '0;
			else if (msTick && rstLowMs_q < sbc_supervisor_pkg::CLAMP_LOW_MS)
				rstLowMs_q <= rstLowMs_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// wake filter and spi inter-frame gap
	// ----------------------------------------------------------------
	logic [sbc_supervisor_pkg::US_CNT_W-1:0] wakeUs_q;
	logic [sbc_supervisor_pkg::US_CNT_W-1:0] csHighUs_q;
	logic                                    csN_q;

	wire wakeDiff = localWakeInput != wakeLevel;
	wire wakeHit  = usTick && wakeDiff
		&& (wakeUs_q == sbc_supervisor_pkg::US_CNT_W'(sbc_supervisor_pkg::WAKE_FILT_US - 1));
	// limitation: a short gap is only reported, the frame itself is not blocked
	wire gapShort = csN_q && !spiCsN && (csHighUs_q < sbc_supervisor_pkg::SPI_GAP_US);

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			wakeUs_q   <= '0;
			wakeLevel  <= 1'b0;
			wakeEvent  <= 1'b0;
			csHighUs_q <= sbc_supervisor_pkg::US_CNT_W'(sbc_supervisor_pkg::SPI_GAP_US);
			csN_q      <= 1'b1;
			lineStatus.spiGapViolation <= 1'b0;
			lineStatus.clampedHigh     <= 1'b0;
			lineStatus.clampedLow      <= 1'b0;
		end
		else
		begin
			wakeEvent <= wakeHit;
			if (wakeHit)
				wakeLevel <= localWakeInput;
			if (!wakeDiff || wakeHit)
				wakeUs_q <= '0;
			else if (usTick)
				wakeUs_q <= wakeUs_q + 1'b1;
			csN_q <= spiCsN;
			if (!spiCsN)
				csHighUs_q <= '0;
			else if (usTick && csHighUs_q < sbc_supervisor_pkg::SPI_GAP_US)
				csHighUs_q <= csHighUs_q + 1'b1;
			lineStatus.spiGapViolation <= lineStatus.spiGapViolation || gapShort;
			// all status fields share this process so the struct has one driver; set wins over clear
			lineStatus.clampedHigh <= clampHiHit || (lineStatus.clampedHigh && resetDriveReq);
			lineStatus.clampedLow  <= clampLoHit || (lineStatus.clampedLow && !resetLineN);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [sbc_supervisor_pkg::US_CNT_W-1:0] chkLowUs_q;
	logic [sbc_supervisor_pkg::US_CNT_W-1:0] chkSinceUs_q;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			chkLowUs_q   <= '0;
			chkSinceUs_q <= sbc_supervisor_pkg::US_CNT_W'(sbc_supervisor_pkg::INT_SPACING_US);
		end
		else
		begin
			if (interruptOeN)
				chkLowUs_q <= '0;
			else if (usTick)
				chkLowUs_q <= chkLowUs_q + 1'b1;
			if (!interruptOeN && $past(interruptOeN))
				chkSinceUs_q <= '0;
			else if (usTick && chkSinceUs_q < sbc_supervisor_pkg::INT_SPACING_US)
				chkSinceUs_q <= chkSinceUs_q + 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_wd_limit_code: assert property (wdLimit == (20'h01f40 << wdSelAct_q))
		else $error("watchdog limit does not match period code");
	a_wd_count_bound: assert property (wdCnt_q < wdLimit)
		else $error("watchdog count ran past its period");
	a_wd_sel_hold: assert property (!wdStart |=> $stable(wdSelAct_q))
		else $error("watchdog period changed mid period");
	a_slow_phase: assert property (!failsafePins.slowOeN |-> $past(slowCnt_q) < 10'h190)
		else $error("slow fail-safe driven outside low phase");
	a_fast_phase: assert property (!failsafePins.fastOeN |-> $past(fastCnt_q) < 10'h002)
		else $error("fast fail-safe driven outside low phase");
	a_failsafe_idle: assert property (!failsafeInternalFlag ##1 !failsafeInternalFlag |-> failsafePins.slowOeN)
		else $error("slow fail-safe driven with no failure");
	a_int_width: assert property ($rose(interruptOeN) |-> $past(chkLowUs_q) >= 13'h3e7)
		else $error("interrupt pulse shorter than 1 ms");
	a_int_max_width: assert property (chkLowUs_q <= 13'h3e8)
		else $error("interrupt pulse longer than 1 ms");
	a_int_spacing: assert property ($fell(interruptOeN) |-> $past(chkSinceUs_q) >= 13'h1387)
		else $error("interrupt requests closer than 5 ms");
	a_rst_filter: assert property (resetDetected |-> $past(!resetLineN, 1) && $past(!resetLineN, 2))
		else $error("reset detected without a held low level");
	a_clamp_high: assert property ($rose(lineStatus.clampedHigh) |-> $past(resetDriveReq && resetLineN))
		else $error("clamped high flagged without drive");
	a_wake_filter: assert property (wakeEvent |-> wakeLevel == $past(localWakeInput, 2))
		else $error("wake accepted on an unsettled level");

endmodule

// >>> bench/spi_master_model.sv
// Purpose: microcontroller side of the spi select line, sending frames with a chosen gap
// Assumes: select idles high, driven high by this model; only the select line matters here
// Notes:   a gap below the minimum is sent only when a test passes a short gap on purpose

module spi_master_model (
	input  wire logic clk_sys, // system clock
	output logic      csN      // spi chip select, active low
);
	timeunit 1ns;
	timeprecision 1ps;

	initial csN = 1'b1;

	// gap counted from the end of the previous frame, which is when a caller re-enters
	task automatic frame(input int gapUs, input int lenCycles);
		repeat (gapUs * sbc_supervisor_pkg::CYCLES_PER_US) @(negedge clk_sys);
		csN = 1'b0;
		repeat (lenCycles) @(negedge clk_sys);
		csN = 1'b1;
	endtask
endmodule

// >>> bench/tb_top.sv
// Purpose: self-checking bench of the supervision timing block
// Assumes: 250 MHz clk_sys; millisecond timers cannot run out within the run
// Notes:   reset pin level resolved here from the open-drain enable and a pull-up

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       flag;
		logic       staticReq;
		logic       fastReq;
		logic       driveReq;
		logic [2:0] expPins;
		logic       expRstOe;
	} row_t;

	logic                               clk_sys = 1'b0;
	logic                               rst_n = 1'b0;
	logic [2:0]                         wdPeriodSelect = 3'h0;
	logic                               wdPeriodWrite = 1'b0;
	logic                               wdTrigger = 1'b0;
	logic                               failsafeInternalFlag = 1'b0;
	logic                               failsafeStaticReq = 1'b0;
	logic                               failsafeFastReq = 1'b0;
	logic                               irqEvent = 1'b0;
	logic                               resetDriveReq = 1'b0;
	logic                               localWakeInput = 1'b0;
	logic                               extResetN = 1'b1;
	logic                               clampHigh = 1'b0;
	wire logic                          spiCsN;
	wire logic                          resetLineN;
	logic                               wdTimeout;
	sbc_supervisor_pkg::failsafe_pins_t failsafePins;
	logic                               interruptOeN;
	logic                               resetLineOeN;
	logic                               resetDetected;
	sbc_supervisor_pkg::line_status_t   lineStatus;
	logic                               wakeEvent;
	logic                               wakeLevel;
	int errors = 0, num_checks = 0, cycleCount = 0;
	int detCount = 0, detCycle = 0, wakeCount = 0, wakeCycle = 0, wdCount = 0;
	int t0, bad;

	row_t rows [8] = '{
		'{1'b0, 1'b0, 1'b0, 1'b0, 3'h7, 1'b1},
		'{1'b0, 1'b1, 1'b0, 1'b0, 3'h3, 1'b1},
		'{1'b1, 1'b0, 1'b0, 1'b1, 3'h5, 1'b0},
		'{1'b0, 1'b0, 1'b1, 1'b0, 3'h6, 1'b1},
		'{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 1'b0},
		'{1'b0, 1'b0, 1'b0, 1'b0, 3'h7, 1'b1},
		'{1'b1, 1'b0, 1'b0, 1'b0, 3'h5, 1'b1},
		'{1'b0, 1'b0, 1'b0, 1'b0, 3'h7, 1'b1}
	};

	// a clamp on the board can hold the line high against the device's pull-down
	assign resetLineN = clampHigh | (resetLineOeN & extResetN);

	always #2 clk_sys = ~clk_sys;

	spi_master_model spi_master_model_inst (
		.clk_sys (clk_sys),
		.csN     (spiCsN)
	);

	sbc_supervisor_timing sbc_supervisor_timing_inst (
		.clk_sys              (clk_sys),
		.rst_n                (rst_n),
		.wdPeriodSelect       (wdPeriodSelect),
		.wdPeriodWrite        (wdPeriodWrite),
		.wdTrigger            (wdTrigger),
		.failsafeInternalFlag (failsafeInternalFlag),
		.failsafeStaticReq    (failsafeStaticReq),
		.failsafeFastReq      (failsafeFastReq),
		.irqEvent             (irqEvent),
		.resetDriveReq        (resetDriveReq),
		.resetLineN           (resetLineN),
		.localWakeInput       (localWakeInput),
		.spiCsN               (spiCsN),
		.wdTimeout            (wdTimeout),
		.failsafePins         (failsafePins),
		.interruptOeN         (interruptOeN),
		.resetLineOeN         (resetLineOeN),
		.resetDetected        (resetDetected),
		.lineStatus           (lineStatus),
		.wakeEvent            (wakeEvent),
		.wakeLevel            (wakeLevel)
	);

	// ----------------------------------------------------------------
	// pulse monitors
	// ----------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		cycleCount <= cycleCount + 1;
		if (resetDetected === 1'b1)
		begin
			detCount <= detCount + 1;
			detCycle <= cycleCount;
		end
		if (wakeEvent === 1'b1)
		begin
			wakeCount <= wakeCount + 1;
			wakeCycle <= cycleCount;
		end
		if (wdTimeout === 1'b1)
			wdCount <= wdCount + 1;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		chk({2'h0, got}, {2'h0, exp}, what);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic check_idle();
		chk(failsafePins, 3'h7, "fail-safe pins idle");
		chk(lineStatus, 3'h0, "line status idle");
		chk({interruptOeN, resetLineOeN, wakeLevel}, 3'h6, "enables and wake level idle");
		chk({wdTimeout, resetDetected, wakeEvent}, 3'h0, "pulses idle");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		// tests take about 45000 cycles; the 75000-cycle limit leaves room and stays far below one 1 ms interrupt pulse
		#300000;
		errors++;
		$display("Error at %0t: run did not finish in time", $time);
		wrap_up();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		wait_n(8);
		check_idle();
		rst_n = 1'b1;
		$display("test reset done");

		// every row also writes one period code and restarts the watchdog with it
		foreach (rows[i])
		begin
			failsafeInternalFlag = rows[i].flag;
			failsafeStaticReq = rows[i].staticReq;
			failsafeFastReq = rows[i].fastReq;
			resetDriveReq = rows[i].driveReq;
			wdPeriodSelect = 3'(i);
			wdPeriodWrite = 1'b1;
			wdTrigger = 1'b1;
			wait_n(1);
			wdPeriodWrite = 1'b0;
			wdTrigger = 1'b0;
			wait_n(2);
			chk(failsafePins, rows[i].expPins, "fail-safe pins");
			chk1(resetLineOeN, rows[i].expRstOe, "reset pin enable");
		end
		$display("test rows done");

		irqEvent = 1'b1;
		wait_n(1);
		irqEvent = 1'b0;
		resetDriveReq = 1'b1;
		clampHigh = 1'b1;
		wait_n(2);
		chk1(interruptOeN, 1'b0, "interrupt pulse start");
		bad = 0;
		for (int i = 0; i < 20000; i++)
		begin
			irqEvent = (i == 100);
			if (interruptOeN !== 1'b0 || lineStatus.clampedHigh !== 1'b0)
				bad++;
			wait_n(1);
		end
		chk1(bad == 0, 1'b1, "interrupt held low, no early clamp flag");
		resetDriveReq = 1'b0;
		clampHigh = 1'b0;
		$display("test interrupt done");

		extResetN = 1'b0;
		wait_n(750);
		extResetN = 1'b1;
		wait_n(1500);
		chk1(detCount == 0, 1'b1, "short reset low taken");
		t0 = cycleCount;
		extResetN = 1'b0;
		wait_n(2000);
		extResetN = 1'b1;
		wait_n(10);
		chk1(detCount == 1, 1'b1, "one reset detection");
		chk1(detCycle - t0 >= 995 && detCycle - t0 <= 1256, 1'b1, "reset filter time");
		chk1(lineStatus.clampedLow, 1'b0, "early clamp low flag");
		$display("test reset filter done");

		localWakeInput = 1'b1;
		wait_n(5000);
		localWakeInput = 1'b0;
		wait_n(100);
		chk1(wakeCount == 0 && wakeLevel === 1'b0, 1'b1, "short wake taken");
		t0 = cycleCount;
		localWakeInput = 1'b1;
		wait_n(8000);
		chk1(wakeCount == 1, 1'b1, "one wake event");
		chk1(wakeLevel, 1'b1, "wake level");
		chk1(wakeCycle - t0 >= 7248 && wakeCycle - t0 <= 7503, 1'b1, "wake filter time");
		$display("test wake done");

		spi_master_model_inst.frame(12, 64);
		spi_master_model_inst.frame(12, 64);
		wait_n(1);
		chk1(lineStatus.spiGapViolation, 1'b0, "gap flag on legal frames");
		spi_master_model_inst.frame(5, 64);
		wait_n(1);
		chk1(lineStatus.spiGapViolation, 1'b1, "gap flag on short gap");
		$display("test spi gap done");

		localWakeInput = 1'b0;
		rst_n = 1'b0;
		wait_n(2);
		check_idle();
		rst_n = 1'b1;
		wait_n(4);
		chk1(lineStatus.spiGapViolation, 1'b0, "gap flag after reset");
		chk1(wdCount == 0, 1'b1, "watchdog expired early");
		$display("test second reset done");
		wrap_up();
	end
endmodule
